// ===== common/move_decode_pkg.sv
// Purpose: constants and types for the coprocessor, multiply and move decoder.
// Assumes: instructions arrive one at a time with their condition already evaluated.
// Notes: narrow forms sit in instr[15:0]; wide forms are first halfword in [31:16].
// What this block does
// - failing condition check leaves registers, flags and coprocessor untouched
// - two-word coprocessor write sends first then second source value
// - no coprocessor accepting means usage fault and no data transfer
// - coprocessor write source register 13 or 15 is unpredictable, both forms
// - 4-bit coprocessor opcode and destination register field passed unchanged
// - 4-bit coprocessor number selects one of sixteen coprocessors
// - multiply-accumulate writes low 32 bits of product plus addend, flags kept
// - multiply-accumulate with accumulate field all ones is a plain multiply
// - multiply-accumulate: d, n, m in 13/15 or a equal 13 unpredictable
// - multiply-subtract writes addend minus low product bits, no flag change
// - multiply-subtract: any register field 13 or 15 is unpredictable
// - byte immediate move zero-extends, keeps carry, sets flags outside if-then
// - expanded-constant move expands with carry, sets flags only when S set
// - wide immediate move zero-extends 16 bits, no flags, d 13/15 unpredictable
// - flag update: N bit 31, Z all zero, C expansion carry, V kept
// - narrow register move uses 4-bit destination, no flags, branches to 15
// - register move to 15 inside if-then block, not last, unpredictable
// - low-register flag-setting move always sets flags, unpredictable in if-then
// - wide register move with SP destination and SP or PC source refused
// - shifted-register moves execute exactly as the matching shift instructions
// - only fixed coprocessor bits decoded; remaining fields passed unchanged
package move_decode_pkg;
	localparam logic [3:0]  REG_SP      = 4'hD;
	localparam logic [3:0]  REG_PC      = 4'hF;
	localparam logic [3:0]  ONES4       = 4'hF;
	localparam int          NB_A        = 4;
	localparam int          NB_B        = 3;
	localparam int          NB_C        = 2;
	localparam int          NB_D        = 1;
	localparam int          NB_E        = 0;
	localparam int          BIT_I       = 26;
	localparam int          BIT_S       = 20;
	localparam int          BIT_HW      = 15;
	localparam int          BIT_DH      = 7;
	localparam logic [2:0]  CP_TOP      = 3'h7;
	localparam logic [7:0]  CP_WR2      = 8'hC4;
	localparam logic [11:0] MAC_GRP     = 12'hFB0;
	localparam logic [3:0]  MAC_ADD     = 4'h0;
	localparam logic [3:0]  MAC_SUB     = 4'h1;
	localparam logic [4:0]  W32_TOP     = 5'h1E;
	localparam logic [4:0]  MOVI_OP     = 5'h02;
	localparam logic [5:0]  WIDE_IMMEDIATE_MOVE_OP     = 6'h24;
	localparam logic [10:0] SHI_OP      = 11'h752;
	localparam logic [8:0]  SHR_OP      = 9'h1F4;
	localparam logic [4:0]  MOVI8_OP    = 5'h04;
	localparam logic [7:0]  MOVHI_OP    = 8'h46;
	localparam logic [9:0]  MOVLO_OP    = 10'h000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_OFFER = 2'b01,
		ST_WORD1 = 2'b10,
		ST_WORD2 = 2'b11
	} fsm_t;

	typedef enum logic [3:0] {
		K_NONE  = 4'h0, K_CPW   = 4'h1, K_MLA   = 4'h2, K_MUL   = 4'h3,
		K_MLS   = 4'h4, K_MOVI8 = 4'h5, K_MOVIX = 4'h6, K_WIDE_IMMEDIATE_MOVE  = 4'h7,
		K_MOVHI = 4'h8, K_MOVLO = 4'h9, K_SHI   = 4'hA, K_SHR   = 4'hB
	} kind_t;

	typedef enum logic [2:0] {
		SH_LSL = 3'b000, SH_LSR = 3'b001, SH_ASR = 3'b010, SH_ROR = 3'b011, SH_RRX = 3'b100
	} shift_t;

	typedef enum logic [1:0] {MAC_MLA = 2'b00, MAC_MUL = 2'b01, MAC_MLS = 2'b10} mac_op_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_t;

	typedef struct packed {
		logic [3:0]  num;
		logic [3:0]  coproc_opcode_field;
		logic [3:0]  coproc_dest_reg_field;
		logic [31:0] instr;
	} cp_offer_t;

	typedef struct packed {
		fsm_t              fsm;
		logic [15:0][31:0] regs;
		flags_t            flags;
		cp_offer_t         offer;
		logic [31:0]       word2;
		logic [31:0]       cp_word;
		logic [31:0]       view;
		logic [31:0]       target;
		logic              done;
		logic              ufault;
		logic              undef;
		logic              branch;
	} dec_state_t;
endpackage : move_decode_pkg

// ===== logic/shift_unit.sv
// Purpose: barrel shifter with carry out for the shifted-move aliases.
// Assumes: amount of zero returns the value and the incoming carry, except for RRX, which always rotates by one.
// Notes: purely combinational.
`timescale 1ns/1ns
module shift_unit (
	input  wire logic                  [31:0] value,
	input  wire move_decode_pkg::shift_t      kind,
	input  wire logic                  [7:0]  amount,
	input  wire logic                         carry_in,
	output logic                       [31:0] result,
	output logic                              carry
);
	logic [32:0] wide_l;
	logic [32:0] wide_r;
	logic [32:0] wide_a;
	logic [63:0] rot;

	always_comb begin
		wide_l = {1'b0, value} << amount;
		wide_r = {value, 1'b0} >> amount;
		wide_a = 33'($signed({value, 1'b0}) >>> amount);
		rot    = {value, value} >> amount[4:0];
		result = value;
		carry  = carry_in;
		if (kind == move_decode_pkg::SH_RRX) begin
			result = {carry_in, value[31:1]};
			carry  = value[0];
		end else if (amount != 8'h00) begin
			case (kind)
				move_decode_pkg::SH_LSL: begin
					result = wide_l[31:0];
					carry  = wide_l[32];
				end
				move_decode_pkg::SH_LSR: begin
					result = wide_r[32:1];
					carry  = wide_r[0];
				end
				move_decode_pkg::SH_ASR: begin
					result = wide_a[32:1];
					carry  = wide_a[0];
				end
				default: begin
					result = rot[31:0];
					carry  = rot[31];
				end
			endcase
		end
	end
endmodule : shift_unit

// ===== logic/mul_acc_unit.sv
// Purpose: 32-bit multiply with optional add or subtract of an accumulator.
// Assumes: only the low product word matters, so sign handling is not needed.
// Notes: combinational; the caller registers the result.
`timescale 1ns/1ns
module mul_acc_unit (
	input  wire move_decode_pkg::mac_op_t        op,
	input  wire logic                   [31:0]   a,
	input  wire logic                   [31:0]   b,
	input  wire logic                   [31:0]   acc,
	output logic                        [31:0]   result
);
	logic [63:0] prod;

	always_comb begin
		prod = a * b;
		case (op)
			move_decode_pkg::MAC_MLS: result = acc - prod[31:0];
			move_decode_pkg::MAC_MUL: result = prod[31:0];
			default:                  result = prod[31:0] + acc;
		endcase
	end
endmodule : mul_acc_unit

// ===== logic/coproc_mul_move_decode.sv
// Purpose: decode and execute coprocessor two-word write, multiply and move forms.
// Assumes: register 15 reads as pc_value; writing it requests a branch instead.
// Notes: one instruction per handshake; coprocessor writes hold instr_ready low.
`timescale 1ns/1ns
module coproc_mul_move_decode (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic                              instr_valid,
	output logic                                   instr_ready,
	input  wire logic                       [31:0] instr,
	input  wire logic                              instr_wide,
	input  wire logic                              cond_pass,
	input  wire logic                              in_it_block,
	input  wire logic                              last_in_it,
	input  wire logic                       [31:0] pc_value,
	input  wire logic                              load_valid,
	input  wire logic                       [3:0]  load_sel,
	input  wire logic                       [31:0] load_data,
	input  wire logic                       [3:0]  view_sel,
	output logic                            [31:0] view_data,
	output move_decode_pkg::flags_t                app_status_flags,
	output logic                                   done,
	output logic                                   usage_fault_exception,
	output logic                                   undef_fault,
	output logic                                   branch_valid,
	output logic                            [31:0] branch_target,
	output logic                                   cp_offer_valid,
	output move_decode_pkg::cp_offer_t             cp_offer,
	input  wire logic                              cp_resp_valid,
	input  wire logic                              cp_accepted,
	output logic                                   cp_word_valid,
	output logic                            [31:0] cp_word,
	input  wire logic                              cp_word_ready
);
	move_decode_pkg::dec_state_t st_ff;
	move_decode_pkg::dec_state_t nxt_st;
	move_decode_pkg::kind_t      kind;
	move_decode_pkg::shift_t     sh_kind;
	move_decode_pkg::mac_op_t    mac_op;
	logic [7:0][3:0] nib;
	logic [3:0]      fa, fb, fc, fe, dest;
	logic [4:0]      imm5;
	logic [7:0]      sh_amt;
	logic [31:0]     va, vb, vc, ve, sh_val, sh_res, mac_res, res, mls_ref;
	logic            sh_c, carry, unpred, setfl, wr, take, res_neg, res_zero;
	logic [32:0]     ximm;

	function automatic logic is_bad(input logic [3:0] r);
		is_bad = (r == move_decode_pkg::REG_SP) || (r == move_decode_pkg::REG_PC);
	endfunction : is_bad

	// expanded constant: replicated byte patterns or a rotated 8-bit value
	function automatic logic [32:0] expand_imm(input logic [11:0] i12, input logic cin);
		logic [31:0] base;
		logic [63:0] rr;
		base = {24'h000000, 1'b1, i12[6:0]};
		rr   = {base, base} >> i12[11:7];
		if (i12[11:10] == 2'b00) begin
			case (i12[9:8])
				2'b00:   expand_imm = {cin, 24'h000000, i12[7:0]};
				2'b01:   expand_imm = {cin, 8'h00, i12[7:0], 8'h00, i12[7:0]};
				2'b10:   expand_imm = {cin, i12[7:0], 8'h00, i12[7:0], 8'h00};
				default: expand_imm = {cin, {4{i12[7:0]}}};
			endcase
		end else begin
			expand_imm = {rr[31], rr[31:0]};
		end
	endfunction : expand_imm

	function automatic logic [31:0] rd_reg(input logic [3:0] r,
		input logic [15:0][31:0] regs, input logic [31:0] pc);
		rd_reg = (r == move_decode_pkg::REG_PC) ? pc : regs[r];
	endfunction : rd_reg

	shift_unit u_shift (
		.value    (sh_val),
		.kind     (sh_kind),
		.amount   (sh_amt),
		.carry_in (st_ff.flags.c),
		.result   (sh_res),
		.carry    (sh_c)
	);

	mul_acc_unit u_mac (
		.op     (mac_op),
		.a      (vb),
		.b      (ve),
		.acc    (va),
		.result (mac_res)
	);

	assign nib         = instr;
	assign instr_ready = (st_ff.fsm == move_decode_pkg::ST_IDLE);
	assign take        = instr_valid && instr_ready;
	assign imm5        = {instr[14:12], instr[7:6]};

	// decode: field pick, operand read and unpredictable check
	always_comb begin
		kind    = move_decode_pkg::K_NONE;
		unpred  = 1'b0;
		fa      = nib[move_decode_pkg::NB_B];
		fb      = nib[move_decode_pkg::NB_A];
		fc      = nib[move_decode_pkg::NB_C];
		fe      = nib[move_decode_pkg::NB_E];
		sh_kind = move_decode_pkg::shift_t'({1'b0, instr[5:4]});
		sh_amt  = {3'b000, imm5};
		mac_op  = move_decode_pkg::MAC_MLA;
		if (instr_wide) begin
			if (instr[31:29] == move_decode_pkg::CP_TOP && instr[27:20] == move_decode_pkg::CP_WR2) begin
				kind   = move_decode_pkg::K_CPW;
				unpred = is_bad(fa) || is_bad(fb);
			end else if (instr[31:20] == move_decode_pkg::MAC_GRP &&
				nib[move_decode_pkg::NB_D] == move_decode_pkg::MAC_ADD) begin
				if (fa == move_decode_pkg::ONES4) begin
					kind   = move_decode_pkg::K_MUL;
					mac_op = move_decode_pkg::MAC_MUL;
					unpred = is_bad(fc) || is_bad(fb) || is_bad(fe);
				end else begin
					kind   = move_decode_pkg::K_MLA;
					unpred = is_bad(fc) || is_bad(fb) || is_bad(fe) ||
						(fa == move_decode_pkg::REG_SP);
				end
			end else if (instr[31:20] == move_decode_pkg::MAC_GRP &&
				nib[move_decode_pkg::NB_D] == move_decode_pkg::MAC_SUB) begin
				kind   = move_decode_pkg::K_MLS;
				mac_op = move_decode_pkg::MAC_MLS;
				unpred = is_bad(fc) || is_bad(fb) || is_bad(fe) || is_bad(fa);
			end else if (instr[31:27] == move_decode_pkg::W32_TOP && !instr[move_decode_pkg::BIT_HW] &&
				instr[25:21] == move_decode_pkg::MOVI_OP && fb == move_decode_pkg::ONES4) begin
				kind   = move_decode_pkg::K_MOVIX;
				unpred = is_bad(fc);
			end else if (instr[31:27] == move_decode_pkg::W32_TOP && !instr[move_decode_pkg::BIT_HW] &&
				instr[25:20] == move_decode_pkg::WIDE_IMMEDIATE_MOVE_OP) begin
				kind   = move_decode_pkg::K_WIDE_IMMEDIATE_MOVE;
				unpred = is_bad(fc);
			end else if (instr[31:21] == move_decode_pkg::SHI_OP && fb == move_decode_pkg::ONES4 &&
				!instr[move_decode_pkg::BIT_HW]) begin
				kind = move_decode_pkg::K_SHI;
				if (instr[5:4] == 2'b00 && imm5 == 5'h00) begin
					unpred = (fc == move_decode_pkg::REG_SP) && is_bad(fe);
				end else begin
					unpred = is_bad(fc) || is_bad(fe);
					if (instr[5:4] == 2'b11 && imm5 == 5'h00) begin
						sh_kind = move_decode_pkg::SH_RRX;
					end else if (instr[5] != instr[4] && imm5 == 5'h00) begin
						sh_amt = 8'h20;
					end
				end
			end else if (instr[31:23] == move_decode_pkg::SHR_OP && fa == move_decode_pkg::ONES4 &&
				nib[move_decode_pkg::NB_D] == 4'h0) begin
				kind    = move_decode_pkg::K_SHR;
				sh_kind = move_decode_pkg::shift_t'({1'b0, instr[22:21]});
				unpred  = is_bad(fc) || is_bad(fb) || is_bad(fe);
			end
		end else begin
			if (instr[15:11] == move_decode_pkg::MOVI8_OP) begin
				kind = move_decode_pkg::K_MOVI8;
				fc   = {1'b0, instr[10:8]};
			end else if (instr[15:8] == move_decode_pkg::MOVHI_OP) begin
				kind   = move_decode_pkg::K_MOVHI;
				fc     = {instr[move_decode_pkg::BIT_DH], instr[2:0]};
				fe     = instr[6:3];
				unpred = (fc == move_decode_pkg::REG_PC) && in_it_block && !last_in_it;
			end else if (instr[15:6] == move_decode_pkg::MOVLO_OP) begin
				kind   = move_decode_pkg::K_MOVLO;
				fc     = {1'b0, instr[2:0]};
				fe     = {1'b0, instr[5:3]};
				sh_amt = 8'h00;
				unpred = in_it_block;
			end
		end
		va     = rd_reg(fa, st_ff.regs, pc_value);
		vb     = rd_reg(fb, st_ff.regs, pc_value);
		vc     = rd_reg(fc, st_ff.regs, pc_value);
		ve     = rd_reg(fe, st_ff.regs, pc_value);
		sh_val = ve;
		if (kind == move_decode_pkg::K_SHR) begin
			sh_val = vb;
			sh_amt = ve[7:0];
		end
	end

	// execute: result, carry and flag selection
	always_comb begin
		ximm  = expand_imm({instr[move_decode_pkg::BIT_I], instr[14:12], instr[7:0]}, st_ff.flags.c);
		res   = 32'h00000000;
		carry = st_ff.flags.c;
		setfl = 1'b0;
		wr    = 1'b1;
		dest  = fc;
		case (kind)
			move_decode_pkg::K_MLA, move_decode_pkg::K_MUL, move_decode_pkg::K_MLS: begin
				res = mac_res;
			end
			move_decode_pkg::K_MOVI8: begin
				res   = {24'h000000, instr[7:0]};
				setfl = !in_it_block;
			end
			move_decode_pkg::K_MOVIX: begin
				res   = ximm[31:0];
				carry = ximm[32];
				setfl = instr[move_decode_pkg::BIT_S];
			end
			move_decode_pkg::K_WIDE_IMMEDIATE_MOVE: begin
				res = {16'h0000, instr[19:16], instr[move_decode_pkg::BIT_I], instr[14:12], instr[7:0]};
			end
			move_decode_pkg::K_MOVHI: begin
				res = ve;
			end
			move_decode_pkg::K_MOVLO: begin
				res   = sh_res;
				setfl = 1'b1;
			end
			move_decode_pkg::K_SHI, move_decode_pkg::K_SHR: begin
				res   = sh_res;
				carry = sh_c;
				setfl = instr[move_decode_pkg::BIT_S];
			end
			default: begin
				wr = 1'b0;
			end
		endcase
		res_neg  = res[31];
		res_zero = (res == 32'h00000000);
		mls_ref  = va - 32'(vb * ve);
	end

	// state update
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.done   = 1'b0;
		nxt_st.ufault = 1'b0;
		nxt_st.undef  = 1'b0;
		nxt_st.branch = 1'b0;
		nxt_st.view   = rd_reg(view_sel, st_ff.regs, pc_value);
		if (load_valid && load_sel != move_decode_pkg::REG_PC) begin
			nxt_st.regs[load_sel] = load_data;
		end
		case (st_ff.fsm)
			move_decode_pkg::ST_IDLE: begin
				if (take && !cond_pass) begin
					nxt_st.done = 1'b1;
				end else if (take && (unpred || kind == move_decode_pkg::K_NONE)) begin
					nxt_st.undef = 1'b1;
				end else if (take && kind == move_decode_pkg::K_CPW) begin
					nxt_st.offer.num                   = nib[move_decode_pkg::NB_C];
					nxt_st.offer.coproc_opcode_field   = nib[move_decode_pkg::NB_D];
					nxt_st.offer.coproc_dest_reg_field = nib[move_decode_pkg::NB_E];
					nxt_st.offer.instr                 = instr;
					nxt_st.cp_word                     = va;
					nxt_st.word2                       = vb;
					nxt_st.fsm                         = move_decode_pkg::ST_OFFER;
				end else if (take) begin
					nxt_st.done = 1'b1;
					if (wr && dest == move_decode_pkg::REG_PC) begin
						nxt_st.branch = 1'b1;
						nxt_st.target = res;
					end else if (wr) begin
						nxt_st.regs[dest] = res;
					end
					if (setfl) begin
						nxt_st.flags.n = res_neg;
						nxt_st.flags.z = res_zero;
						nxt_st.flags.c = carry;
					end
				end
			end
			move_decode_pkg::ST_OFFER: begin
				if (cp_resp_valid && cp_accepted) begin
					nxt_st.fsm = move_decode_pkg::ST_WORD1;
				end else if (cp_resp_valid) begin
					nxt_st.ufault = 1'b1;
					nxt_st.done   = 1'b1;
					nxt_st.fsm    = move_decode_pkg::ST_IDLE;
				end
			end
			move_decode_pkg::ST_WORD1: begin
				if (cp_word_ready) begin
					nxt_st.cp_word = st_ff.word2;
					nxt_st.fsm     = move_decode_pkg::ST_WORD2;
				end
			end
			default: begin
				if (cp_word_ready) begin
					nxt_st.done = 1'b1;
					nxt_st.fsm  = move_decode_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign view_data             = st_ff.view;
	assign app_status_flags      = st_ff.flags;
	assign done                  = st_ff.done;
	assign usage_fault_exception = st_ff.ufault;
	assign undef_fault           = st_ff.undef;
	assign branch_valid          = st_ff.branch;
	assign branch_target         = st_ff.target;
	assign cp_offer_valid        = (st_ff.fsm == move_decode_pkg::ST_OFFER);
	assign cp_offer              = st_ff.offer;
	assign cp_word_valid         = st_ff.fsm[1];
	assign cp_word               = st_ff.cp_word;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_accept;
		cp_offer_valid && cp_resp_valid && cp_accepted;
	endsequence
	sequence s_first_word;
		st_ff.fsm == move_decode_pkg::ST_WORD1 && cp_word_ready;
	endsequence

	chk_cond_quiet: assert property (take && !cond_pass && !load_valid |=>
		done && $stable(st_ff.regs) && $stable(app_status_flags) && !cp_offer_valid)
		else $error("failed condition changed state");
	chk_cp_first_word: assert property (take && cond_pass && !unpred &&
		kind == move_decode_pkg::K_CPW |=> cp_offer_valid && !cp_word_valid && cp_word == $past(va))
		else $error("coprocessor first word wrong");
	chk_accept_word: assert property (s_accept |=>
		cp_word_valid && cp_word == $past(cp_word))
		else $error("first word not presented after acceptance");
	chk_cp_word_order: assert property (s_first_word |=>
		st_ff.fsm == move_decode_pkg::ST_WORD2 && cp_word == $past(st_ff.word2))
		else $error("second word not sent after first");
	chk_reject_fault: assert property (cp_offer_valid && cp_resp_valid && !cp_accepted |=>
		usage_fault_exception && !cp_word_valid && instr_ready)
		else $error("rejection did not fault");
	chk_unpred_trap: assert property (take && cond_pass && unpred && !load_valid |=>
		undef_fault && $stable(st_ff.regs) && !done)
		else $error("unpredictable form not trapped");
	chk_mls_value: assert property (take && cond_pass && !unpred &&
		kind == move_decode_pkg::K_MLS |=> st_ff.regs[$past(dest)] == $past(mls_ref)
		&& $stable(app_status_flags))
		else $error("multiply-subtract result wrong");
	chk_mac_flags: assert property (take && cond_pass && !unpred &&
		(kind == move_decode_pkg::K_MLA || kind == move_decode_pkg::K_MUL) |=>
		$stable(app_status_flags) && st_ff.regs[$past(dest)] ==
		$past(32'(vb * ve) + ((kind == move_decode_pkg::K_MUL) ? 32'h00000000 : va)))
		else $error("multiply-accumulate result or flags wrong");
	chk_imm_flags: assert property (take && cond_pass && !unpred &&
		kind == move_decode_pkg::K_MOVIX && instr[move_decode_pkg::BIT_S] |=>
		app_status_flags == {$past(res_neg), $past(res_zero), $past(carry), $past(st_ff.flags.v)})
		else $error("expanded move flags wrong");
	chk_wide_noflags: assert property (take && cond_pass && !unpred &&
		kind == move_decode_pkg::K_WIDE_IMMEDIATE_MOVE |=> $stable(app_status_flags))
		else $error("wide immediate move touched flags");
	chk_pc_branch: assert property (take && cond_pass && !unpred &&
		kind == move_decode_pkg::K_MOVHI && dest == move_decode_pkg::REG_PC |=>
		branch_valid && branch_target == $past(ve) ##1 !branch_valid)
		else $error("move to pc did not branch once");
	chk_it_pc_move: assert property (take && cond_pass && kind == move_decode_pkg::K_MOVHI &&
		dest == move_decode_pkg::REG_PC && in_it_block && !last_in_it |=> undef_fault && !branch_valid)
		else $error("pc move inside if-then block not trapped");
endmodule : coproc_mul_move_decode

// ===== dv/coproc_model.sv
// Purpose: far-side coprocessor that answers offers and takes words.
// Assumes: accept_mask bit n means coprocessor n is present.
// Notes: ready toggles, so every word sees one stall cycle.
`timescale 1ns/1ns
module coproc_model (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [15:0]                accept_mask,
	input  wire logic                       cp_offer_valid,
	input  wire move_decode_pkg::cp_offer_t cp_offer,
	output logic                            cp_resp_valid,
	output logic                            cp_accepted,
	input  wire logic                       cp_word_valid,
	input  wire logic [31:0]                cp_word,
	output logic                            cp_word_ready,
	output move_decode_pkg::cp_offer_t      seen_offer,
	output logic [31:0]                     word_a,
	output logic [31:0]                     word_b,
	output logic [3:0]                      word_count
);
	always_ff @(posedge clk) begin
		if (rst) begin
			{cp_resp_valid, cp_accepted, cp_word_ready, word_count} <= '0;
		end else begin
			cp_resp_valid <= cp_offer_valid && !cp_resp_valid;
			// the answer line toggles while no offer is presented so a stale value never looks valid
			cp_accepted <= cp_offer_valid ? accept_mask[cp_offer.num] : !cp_accepted;
			if (cp_offer_valid && !cp_resp_valid) begin
				seen_offer <= cp_offer;
			end
			cp_word_ready <= cp_word_valid && !cp_word_ready;
			if (cp_word_valid && cp_word_ready) begin
				if (word_count[0]) word_b <= cp_word;
				else word_a <= cp_word;
				word_count <= word_count + 4'h1;
			end
		end
	end
endmodule : coproc_model

// ===== dv/coproc_mul_move_decode_tb.sv
// Purpose: self-checking bench for the decoder.
// Assumes: r0..r3 preloaded with 3, 5, 7, 9.
// Notes: ordinary cases are table rows; faults are hand-written.
`timescale 1ns/1ns
module coproc_mul_move_decode_tb;
	typedef struct packed {logic [31:0] i; logic w; logic [3:0] d; logic [31:0] v; logic [3:0] f;} row_t;
	logic clk = 0, rst = 1, iv = 0, wide = 0, cp = 1, it = 0, lst = 0, lv = 0, rdy, dn, uf, ud, bv;
	logic ov, rv, ac, wv, wr, sd, sf, su, sb;
	logic [31:0] ins = 0, ld = 0, vd, bt, w, tgt, wa, wb;
	logic [3:0] ls = 0, vs = 0, wn;
	move_decode_pkg::flags_t fl;
	move_decode_pkg::cp_offer_t of, so;
	int fail_count = 0, check_count = 0, cyc = 0;
	row_t rows [11] = '{'{32'hF2412634, 1, 6, 32'h1234, 0}, '{32'hFB003201, 1, 2, 32'h18, 0},
		'{32'hFB003211, 1, 2, 32'hFFFFFFFA, 0}, '{32'hFB00F201, 1, 2, 32'hF, 0},
		'{32'h2400, 0, 4, 0, 4'h4}, '{32'h460D, 0, 5, 5, 4'h4}, '{32'hF05F4700, 1, 7, 32'h80000000, 4'hA},
		'{32'h2400, 0, 4, 0, 4'h6}, '{32'hEA4F1701, 1, 7, 32'h50, 4'h6},
		'{32'h001C, 0, 4, 32'h9, 4'h2}, '{32'hFA33F800, 1, 8, 32'h1, 0}};
	logic [31:0] bad [7] = '{32'hF2412D34, 32'hFB003F01, 32'hFB00D211, 32'hEC40D537,
		32'hEA4F0D0D, 32'h8, 32'h468F};
	coproc_mul_move_decode dut (.clk(clk), .rst(rst), .instr_valid(iv), .instr_ready(rdy), .instr(ins),
		.instr_wide(wide), .cond_pass(cp), .in_it_block(it), .last_in_it(lst), .pc_value(32'h100),
		.load_valid(lv), .load_sel(ls), .load_data(ld), .view_sel(vs), .view_data(vd),
		.app_status_flags(fl), .done(dn), .usage_fault_exception(uf), .undef_fault(ud),
		.branch_valid(bv), .branch_target(bt), .cp_offer_valid(ov), .cp_offer(of), .cp_resp_valid(rv),
		.cp_accepted(ac), .cp_word_valid(wv), .cp_word(w), .cp_word_ready(wr));
	coproc_model cpm (.clk(clk), .rst(rst), .accept_mask(16'h0020), .cp_offer_valid(ov), .cp_offer(of),
		.cp_resp_valid(rv), .cp_accepted(ac), .cp_word_valid(wv), .cp_word(w), .cp_word_ready(wr),
		.seen_offer(so), .word_a(wa), .word_b(wb), .word_count(wn));
	task chk(input logic [31:0] a, input logic [31:0] e);
		check_count++;
		if (a !== e) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, a, e);
		end
	endtask : chk
	task end_sim;
		if (fail_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	task go(input logic [31:0] i, input logic wd, input logic c, input logic t, input logic l);
		@(posedge clk);
		{ins, wide, cp, it, lst, iv} <= {i, wd, c, t, l, 1'b1};
		@(posedge clk);
		iv <= 0;
		{sd, su, sf, sb} = 0;
		for (int k = 0; k < 12 && !(sd | su); k++) begin
			@(negedge clk);
			{sb, sf, sd, su} = {sb | bv, sf | uf, dn, ud};
			if (bv) tgt = bt;
		end
	endtask : go
	task rd(input logic [3:0] s, input logic [31:0] e);
		@(posedge clk);
		vs <= s;
		@(posedge clk);
		@(negedge clk);
		chk(vd, e);
	endtask : rd
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		for (int j = 0; j < 4; j++) begin
			@(posedge clk);
			{lv, ls, ld} <= {1'b1, 4'(j), 32'(j * 2 + 3)};
		end
		@(posedge clk);
		lv <= 0;
		foreach (rows[j]) begin
			go(rows[j].i, rows[j].w, 1, 0, 0);
			rd(rows[j].d, rows[j].v);
			chk(32'(fl), 32'(rows[j].f));
		end
		go(32'hF2412699, 1, 0, 0, 0);
		chk(32'(sd), 1);
		rd(6, 32'h1234);
		foreach (bad[j]) begin
			go(bad[j], j < 5, 1, j > 4, 0);
			chk(32'(su), 1);
		end
		for (int j = 0; j < 2; j++) begin
			go(32'h468F, 0, 1, j, j);
			chk(32'(sb), 1);
			chk(tgt, 32'h5);
		end
		for (int j = 0; j < 2; j++) begin
			go(32'hEC401537 | (32'(j) << 28), 1, 1, 0, 0);
			chk(32'({sf, sd, wn}), 32'({1'b0, 1'b1, 4'(j * 2 + 2)}));
			chk(wa, 32'h5);
			chk(wb, 32'h3);
			chk(32'({so.num, so.coproc_opcode_field, so.coproc_dest_reg_field}), 32'h537);
		end
		go(32'hEC401237, 1, 1, 0, 0);
		chk(32'({sf, sd, wn}), 32'h34);
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk({fl, rdy}, 5'h1);
		rd(2, 0);
		end_sim();
	end
endmodule : coproc_mul_move_decode_tb
